// file: dv/testbench.sv
// Self-checking bench for tla_link: registers, pass modes, merging and send rules.
// Assumes the far-side model offers the message slots and captures the output.
`timescale 1ns/1ps
`include "tla_regs.vh"
module testbench;
    reg clk_sys_in = 1'b0;
    reg rst_n_in = 1'b0;
    reg [7:0] addr_in = 8'h00;
    reg [31:0] wdata_in = 32'h00000000;
    reg wr_in = 1'b0;
    reg rd_in = 1'b0;
    reg frame_tick_in = 1'b0;
    wire msg_valid_in, tx_now_out, out_valid_out, error_out;
    wire [12:0] cd_addr_in, pe_ts_in, out_addr_out;
    wire [4:0] cd_type_in, out_type_out;
    wire [7:0] cd_ts_in;
    wire [63:0] cd_payload_in, pe_payload_in, out_payload_out, mac_word;
    wire [31:0] rdata_out;
    wire [4:0] sc_idx;
    wire pk_flag, ts_adv;
    wire [1:0] pk_pick, fmt;
    integer err_total = 0;
    integer n_compared = 0;
    integer n;
    reg [31:0] rv;
    tla_link u_tla_link (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .frame_tick_in(frame_tick_in), .msg_valid_in(msg_valid_in), .cd_addr_in(cd_addr_in),
        .cd_type_in(cd_type_in), .cd_ts_in(cd_ts_in), .cd_payload_in(cd_payload_in),
        .pe_ts_in(pe_ts_in), .pe_payload_in(pe_payload_in), .tx_now_out(tx_now_out),
        .stream_or_control_index_out(sc_idx), .circuit_packet_flag_out(pk_flag),
        .timestamp_advance_bit_out(ts_adv), .packet_counter_pick_out(pk_pick),
        .data_format_out(fmt),
        .out_valid_out(out_valid_out), .out_addr_out(out_addr_out),
        .out_type_out(out_type_out), .out_payload_out(out_payload_out), .error_out(error_out));
    tla_far_model u_tla_far_model (.clk_sys_in(clk_sys_in), .out_valid_in(out_valid_out),
        .out_payload_in(out_payload_out), .msg_valid_out(msg_valid_in),
        .cd_addr_out(cd_addr_in), .cd_type_out(cd_type_in), .cd_ts_out(cd_ts_in),
        .cd_payload_out(cd_payload_in), .pe_ts_out(pe_ts_in), .pe_payload_out(pe_payload_in),
        .mac_word_out(mac_word));
    // The 20 MHz system clock.
    always #25 clk_sys_in = ~clk_sys_in;
    // Counts a comparison and reports a mismatch at once.
    task check(input [63:0] got, input [63:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // One-cycle register write.
    task wr(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys_in);
            {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
            @(posedge clk_sys_in);
            wr_in <= 1'b0;
        end
    endtask
    // One-cycle register read; the data is taken in the following cycle.
    task rd(input [7:0] a, output [31:0] d);
        begin
            @(posedge clk_sys_in);
            {addr_in, rd_in} <= {a, 1'b1};
            @(posedge clk_sys_in);
            rd_in <= 1'b0;
            #1 d = rdata_out;
        end
    endtask
    // Offers one slot; returns just after the edge that produced the answer.
    task msg(input [4:0] t, input [63:0] cp, input [63:0] pp);
        begin
            u_tla_far_model.send(t, cp, pp);
            #1;
        end
    endtask
    // Register reset value, read-back, and refused accesses.
    task t_regs;
        begin
            rd(`TLA_ADDR_CTRL, rv);
            check(rv, `TLA_CTRL_RESET);
            wr(`TLA_ADDR_TERM, 32'hA5C31E07);
            wr(8'h10, 32'hFFFFFFFF);
            rd(`TLA_ADDR_TERM, rv);
            check(rv, 32'hA5C31E07);
            rd(8'h10, rv);
            check(rv, 32'h0);
            wr(`TLA_ADDR_TERM, 32'h0);
            $display("test regs done");
        end
    endtask
    // Loop-back of the combiner stream and send-out of the encoder stream.
    task t_pass;
        begin
            for (n = 0; n < 3; n = n + 1) begin
                wr(`TLA_ADDR_CTRL, n << 2);
                msg(`TLA_TYPE_WCDMA, 64'h0123456789ABCDEF, 64'hFEDCBA9876543210);
                @(posedge clk_sys_in);
                #1 check(mac_word, (n < 2) ? 64'h0123456789ABCDEF : 64'hFEDCBA9876543210);
            end
            $display("test pass done");
        end
    endtask
    // One merged slot under identity entry 0 with merge mode mm.
    task merge_case(input [1:0] mm, input [4:0] t, input [63:0] cp, input [63:0] pp,
        input [63:0] ep, input ee);
        begin
            wr(`TLA_ADDR_IDTAB0, {8'h00, mm, 4'h0, `TLA_TYPE_WCDMA, 13'h0123});
            msg(t, cp, pp);
            check(out_payload_out, ep);
            check(error_out, ee);
            check(out_addr_out, 13'h0123);
            check(out_type_out, (t == `TLA_TYPE_CTRL) ? t : `TLA_TYPE_WCDMA);
            @(posedge clk_sys_in);
            #1 check(mac_word, ep);
        end
    endtask
    // Saturating sums at both widths and insertion over empty and busy slots.
    task t_merge;
        begin
            for (n = 0; n < 42; n = n + 1) begin
                wr(`TLA_ADDR_SLOTTAB + n, 32'h0);
            end
            wr(`TLA_ADDR_IDTAB1, 32'h0);
            wr(`TLA_ADDR_CTRL, 32'h1C);
            merge_case(`TLA_MM_SUM16, `TLA_TYPE_WCDMA, 64'h7FF080101234_0001,
                64'h002080001111FFFF, 64'h7FFF800023450000, 1'b1);
            merge_case(`TLA_MM_SUM8, `TLA_TYPE_WCDMA, 64'h0102030405060708,
                64'h10107F10F010100F, 64'h11127F14F5161717, 1'b1);
            merge_case(`TLA_MM_SUM16, `TLA_TYPE_EMPTY, 64'h0, 64'h3333, 64'h3333, 1'b0);
            merge_case(`TLA_MM_PASS, `TLA_TYPE_WCDMA, 64'h1111, 64'h2222, 64'h1111, 1'b0);
            merge_case(`TLA_MM_INSERT, `TLA_TYPE_EMPTY, 64'h0, 64'hC0DE, 64'hC0DE, 1'b0);
            merge_case(`TLA_MM_INSERT, `TLA_TYPE_CTRL, 64'hBEEF, 64'hC0DE, 64'hBEEF, 1'b1);
            rd(`TLA_ADDR_ERRS, rv);
            check(rv, 32'h00000003);
            wr(`TLA_ADDR_ERRS, 32'hFFFFFFFF);
            rd(`TLA_ADDR_ERRS, rv);
            check(rv, 32'h00000000);
            $display("test merge done");
        end
    endtask
    // Data-slot send rule after a frame tick, then counter and slot index read back.
    task t_rule(input [10:0] mask, input [10:0] cmp);
        begin
            wr(`TLA_ADDR_IDTAB1, {5'h0, cmp, 5'h0, mask});
            wr(`TLA_ADDR_SLOTTAB, 32'h00001860);
            @(posedge clk_sys_in);
            frame_tick_in <= 1'b1;
            repeat (2) @(posedge clk_sys_in);
            frame_tick_in <= 1'b0;
            repeat (4) @(posedge clk_sys_in);
            for (n = 0; n < 16; n = n + 1) begin
                msg(`TLA_TYPE_WCDMA, 64'h1, 64'h2);
                check(tx_now_out, ((n[10:0] ^ cmp) & mask) == 11'h0);
                check({sc_idx, pk_flag, ts_adv, pk_pick, fmt}, (n == 0) ? 11'h03C : 11'h000);
            end
            rd(`TLA_ADDR_STAT, rv);
            check(rv & 32'h0007FFFF, 32'h00001010);
            $display("test rule done");
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task finish_test;
        begin
            $display("compared %0d mismatches %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Reset, then the scenarios in order.
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        t_regs;
        t_pass;
        t_merge;
        t_rule(11'h007, 11'h002);
        t_rule(11'h000, 11'h000);
        finish_test;
    end
    // Cuts a hang short well after the scenarios should have ended.
    initial begin
        #1000000;
        err_total = err_total + 1;
        finish_test;
    end
endmodule // testbench

// file: dv/tla_far_model.sv
// Far side: presents combiner and encoder messages in step, captures the merged output.
// Assumes the same clock as the transmit-link block.
`timescale 1ns/1ps
module tla_far_model (
    input wire clk_sys_in,
    input wire out_valid_in,
    input wire [63:0] out_payload_in,
    output reg msg_valid_out,
    output reg [12:0] cd_addr_out,
    output reg [4:0] cd_type_out,
    output reg [7:0] cd_ts_out,
    output reg [63:0] cd_payload_out,
    output reg [12:0] pe_ts_out,
    output reg [63:0] pe_payload_out,
    output reg [63:0] mac_word_out
);
    // Lines start quiet with no message offered.
    initial begin
        msg_valid_out = 1'b0;
        {cd_addr_out, cd_type_out, cd_ts_out, cd_payload_out, pe_ts_out, pe_payload_out} = 'h0;
        mac_word_out = 64'h0;
    end
    // One slot: both streams offered in the same cycle, then scrambled so stale data is useless.
    task send(input [4:0] t, input [63:0] cp, input [63:0] pp);
        begin
            @(posedge clk_sys_in);
            msg_valid_out <= 1'b1;
            {cd_addr_out, cd_type_out, cd_ts_out} <= {13'h0123, t, 8'h10};
            {cd_payload_out, pe_ts_out, pe_payload_out} <= {cp, 13'h0010, pp};
            @(posedge clk_sys_in);
            msg_valid_out <= 1'b0;
            {cd_addr_out, cd_type_out, cd_ts_out} <= ~{13'h0123, t, 8'h10};
            {cd_payload_out, pe_ts_out, pe_payload_out} <= ~{cp, 13'h0010, pp};
        end
    endtask
    // The transmit MAC side keeps the last merged payload.
    always @(posedge clk_sys_in) begin
        if (out_valid_in) begin
            mac_word_out <= out_payload_in;
        end
    end
endmodule // tla_far_model

// file: dv/tla_link_properties.sv
// Checker for tla_link: message timing, output holding and register reads.
// Assumes it is bound to tla_link and sees only that module's ports.
`timescale 1ns/1ps
`include "tla_regs.vh"
module tla_link_checker (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [31:0] rdata_out,
    input wire msg_valid_in,
    input wire [4:0] cd_type_in,
    input wire [63:0] cd_payload_in,
    input wire [63:0] pe_payload_in,
    input wire out_valid_out,
    input wire [4:0] out_type_out,
    input wire [63:0] out_payload_out,
    input wire [4:0] stream_or_control_index_out,
    input wire circuit_packet_flag_out,
    input wire [1:0] packet_counter_pick_out
);
    reg [1:0] mode_reg;
    reg [31:0] term_reg;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // Shadow copies of the link mode and termination counts written by software.
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_reg <= 2'h0;
            term_reg <= 32'h00000000;
        end else if (wr_in && addr_in == `TLA_ADDR_CTRL) begin
            mode_reg <= wdata_in[3:2];
        end else if (wr_in && addr_in == `TLA_ADDR_TERM) begin
            term_reg <= wdata_in;
        end
    end
    msg_answer_a: assert property (msg_valid_in |=> out_valid_out)
        else $error("message slot gave no output");
    valid_pulse_a: assert property (!msg_valid_in |=> !out_valid_out)
        else $error("output valid without a message slot");
    read_idle_a: assert property (!rd_in |=> rdata_out == 32'h00000000)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (rd_in && addr_in == 8'h10 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    term_readback_a: assert property (rd_in && addr_in == `TLA_ADDR_TERM |=> rdata_out == term_reg)
        else $error("termination counts read back wrong");
    payload_hold_a: assert property (!msg_valid_in |=> $stable(out_payload_out) && $stable(out_type_out))
        else $error("merged message changed between slots");
    slot_fields_a: assert property (!msg_valid_in |=> $stable(stream_or_control_index_out)
        && $stable(circuit_packet_flag_out) && $stable(packet_counter_pick_out))
        else $error("slot fields changed between slots");
    pass_combiner_a: assert property (msg_valid_in && !mode_reg[1] |=>
        out_payload_out == $past(cd_payload_in) && out_type_out == $past(cd_type_in))
        else $error("combiner message not looped out");
    pass_encoder_a: assert property (msg_valid_in && mode_reg == `TLA_MODE_PASS_PE |=>
        out_payload_out == $past(pe_payload_in))
        else $error("encoder message not sent out");
endmodule // tla_link_checker
bind tla_link tla_link_checker u_tla_link_checker (.clk_sys_in, .rst_n_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .msg_valid_in, .cd_type_in, .cd_payload_in, .pe_payload_in,
    .out_valid_out, .out_type_out, .out_payload_out, .stream_or_control_index_out,
    .circuit_packet_flag_out, .packet_counter_pick_out);

// file: logic/tla_link.v
// One transmit link: slot scheduler, transmission rules and merge unit.
// Assumes one message per msg_valid_in pulse, aligned encoder and combiner streams.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "tla_regs.vh"
module tla_link (
    input wire clk_sys_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    input wire frame_tick_in,
    input wire msg_valid_in,
    input wire [12:0] cd_addr_in,
    input wire [4:0] cd_type_in,
    input wire [7:0] cd_ts_in,
    input wire [63:0] cd_payload_in,
    input wire [12:0] pe_ts_in,
    input wire [63:0] pe_payload_in,
    output reg tx_now_out,
    output reg [4:0] stream_or_control_index_out,
    output reg circuit_packet_flag_out,
    output reg timestamp_advance_bit_out,
    output reg [1:0] packet_counter_pick_out,
    output reg [1:0] data_format_out,
    output reg out_valid_out,
    output reg [12:0] out_addr_out,
    output reg [4:0] out_type_out,
    output reg [63:0] out_payload_out,
    output reg error_out
);
    reg rst_s1_reg;
    reg rst_s2_reg;
    reg tick_s1_reg;
    reg tick_s2_reg;
    reg tick_s3_reg;
    reg [31:0] ctrl_reg;
    reg [31:0] term_reg;
    reg [31:0] errs_reg;
    reg [15:0] slot_tab [0:83];
    reg [31:0] id_tab0 [0:20];
    reg [31:0] id_tab1 [0:20];
    reg [6:0] slot_reg;
    reg [10:0] data_cnt_reg;
    reg [7:0] ctl_cnt_reg [0:3];
    reg [6:0] msg_div_reg;
    reg ctl_upd_reg;
    reg [1:0] ctl_sel_reg;
    reg [7:0] ctl_cmp_reg;
    wire rst_n;
    wire tick;
    wire [1:0] mode;
    wire [1:0] rate;
    wire wide;
    wire [15:0] slot_ent;
    wire [4:0] idx;
    wire [31:0] ide0;
    wire [31:0] ide1;
    wire [2:0] csel;
    wire [10:0] msk;
    wire [10:0] cmp;
    wire [7:0] term;
    wire data_hit;
    wire ctl_hit;
    wire hit;
    wire [1:0] mm;
    wire [6:0] div_last;
    wire [63:0] sum;
    wire ovf;
    wire cd_empty;
    wire pe_empty;
    wire [4:0] pe_type;
    wire [12:0] pe_addr;
    integer k;

    // Saturating add of one 16-bit lane, or of its two bytes apart when w16 is low.
    function [16:0] sat_add;
        input [15:0] a;
        input [15:0] b;
        input w16;
        reg [16:0] s;
        reg [8:0] s8;
        reg [8:0] h8;
        begin
            s = {a[15], a} + {b[15], b};
            s8 = {a[7], a[7:0]} + {b[7], b[7:0]};
            h8 = {a[15], a[15:8]} + {b[15], b[15:8]};
            if (w16) begin
                if (s[16] != s[15]) begin
                    sat_add = {1'b1, s[16] ? 16'h8000 : 16'h7FFF};
                end else begin
                    sat_add = {1'b0, s[15:0]};
                end
            end else begin
                sat_add[16] = (s8[8] != s8[7]) | (h8[8] != h8[7]);
                sat_add[15:8] = (h8[8] != h8[7]) ? (h8[8] ? 8'h80 : 8'h7F) : h8[7:0];
                sat_add[7:0] = (s8[8] != s8[7]) ? (s8[8] ? 8'h80 : 8'h7F) : s8[7:0];
            end
        end
    endfunction

    // Reset release through two flip-flops.
    always @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    assign rst_n = rst_s2_reg;

    // The 10 ms tick arrives from outside; synchronise and detect its edge.
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tick_s1_reg <= 1'b0;
            tick_s2_reg <= 1'b0;
            tick_s3_reg <= 1'b0;
        end else begin
            tick_s1_reg <= frame_tick_in;
            tick_s2_reg <= tick_s1_reg;
            tick_s3_reg <= tick_s2_reg;
        end
    end
    assign tick = tick_s2_reg & ~tick_s3_reg;

    // Control: [1:0] link rate 0=1x 1=2x 2=4x, [3:2] link mode off/pass combiner/pass encoder/merge, [4] unused; merge mode picks 8/16 widths.
    assign rate = ctrl_reg[1:0];
    assign mode = ctrl_reg[3:2];
    assign wide = ctrl_reg[4];
    assign div_last = (rate == 2'h0) ? 7'd20 : (rate == 2'h1) ? 7'd41 : 7'd83;

    // Table lookups for the current slot.
    assign slot_ent = slot_tab[slot_reg];
    assign idx = slot_ent[4:0];
    assign ide0 = id_tab0[idx];
    assign ide1 = id_tab1[idx];
    assign csel = slot_ent[10:8];
    assign msk = ide1[10:0];
    assign cmp = ide1[26:16];
    assign term = term_reg[{ctl_sel_reg, 3'b000} +: 8];
    assign data_hit = ((data_cnt_reg ^ cmp) & msk) == 11'h000;
    assign ctl_hit = (ctl_cnt_reg[csel[1:0]] == cmp[7:0]);
    assign hit = csel[2] ? ctl_hit : data_hit;
    assign mm = ide0[23:22];
    assign pe_addr = ide0[12:0];
    assign pe_type = hit ? ide0[17:13] : `TLA_TYPE_EMPTY;
    assign cd_empty = (cd_type_in == `TLA_TYPE_EMPTY);
    assign pe_empty = (pe_type == `TLA_TYPE_EMPTY);

    // Four saturating lanes: I and Q of two samples, each saturated alone.
    wire [16:0] l0 = sat_add(pe_payload_in[15:0], cd_payload_in[15:0], mm[0]);
    wire [16:0] l1 = sat_add(pe_payload_in[31:16], cd_payload_in[31:16], mm[0]);
    wire [16:0] l2 = sat_add(pe_payload_in[47:32], cd_payload_in[47:32], mm[0]);
    wire [16:0] l3 = sat_add(pe_payload_in[63:48], cd_payload_in[63:48], mm[0]);
    assign sum = {l3[15:0], l2[15:0], l1[15:0], l0[15:0]};
    assign ovf = l0[16] | l1[16] | l2[16] | l3[16];

    // Register writes: control and termination counts.
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `TLA_CTRL_RESET;
            term_reg <= 32'h00000000;
        end else if (wr_in) begin
            if (addr_in == `TLA_ADDR_CTRL) begin
                ctrl_reg <= wdata_in;
            end
            if (addr_in == `TLA_ADDR_TERM) begin
                term_reg <= wdata_in;
            end
        end
    end

    // Table memories hold no reset; software loads them before enabling.
    always @(posedge clk_sys_in) begin
        if (wr_in && addr_in[7:6] == 2'b01 && addr_in[5:0] < 6'd42) begin
            slot_tab[{addr_in[5:0], 1'b0}] <= wdata_in[15:0];
            slot_tab[{addr_in[5:0], 1'b1}] <= wdata_in[31:16];
        end
        if (wr_in && addr_in[7:5] == 3'b101 && addr_in[4:0] < `TLA_IDS) begin
            id_tab0[addr_in[4:0]] <= wdata_in;
        end
        if (wr_in && addr_in[7:5] == 3'b110 && addr_in[4:0] < `TLA_IDS) begin
            id_tab1[addr_in[4:0]] <= wdata_in;
        end
    end

    // Slot index, data counter and control counters.
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            slot_reg <= 7'h00;
            data_cnt_reg <= 11'h000;
            msg_div_reg <= 7'h00;
            ctl_upd_reg <= 1'b0;
            ctl_sel_reg <= 2'h0;
            for (k = 0; k < 4; k = k + 1) begin
                ctl_cnt_reg[k] <= 8'h00;
            end
        end else if (tick) begin
            slot_reg <= 7'h00;
            data_cnt_reg <= 11'h000;
            msg_div_reg <= 7'h00;
            ctl_upd_reg <= 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                ctl_cnt_reg[k] <= 8'h00;
            end
        end else begin
            ctl_upd_reg <= 1'b0;
            if (msg_valid_in) begin
                slot_reg <= (slot_reg == `TLA_SLOTS - 7'h01) ? 7'h00 : slot_reg + 7'h01;
                if (!csel[2]) begin
                    data_cnt_reg <= (data_cnt_reg == `TLA_DATA_LAST) ? 11'h000 :
                        data_cnt_reg + 11'h001;
                end
                msg_div_reg <= (msg_div_reg == div_last) ? 7'h00 : msg_div_reg + 7'h01;
                if (csel[2] && msg_div_reg == 7'h00) begin
                    ctl_upd_reg <= 1'b1;
                    ctl_sel_reg <= csel[1:0];
                end
            end
            if (ctl_upd_reg) begin
                ctl_cnt_reg[ctl_sel_reg] <= (ctl_cnt_reg[ctl_sel_reg] >= term) ? 8'h00 :
                    ctl_cnt_reg[ctl_sel_reg] + 8'h01;
            end
        end
    end

    // Merge unit: positional combine of encoder and combiner messages.
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_now_out <= 1'b0;
            stream_or_control_index_out <= 5'h00;
            circuit_packet_flag_out <= 1'b0;
            timestamp_advance_bit_out <= 1'b0;
            packet_counter_pick_out <= 2'h0;
            data_format_out <= 2'h0;
            out_valid_out <= 1'b0;
            out_addr_out <= 13'h0000;
            out_type_out <= 5'h00;
            out_payload_out <= 64'h0;
            error_out <= 1'b0;
            errs_reg <= 32'h00000000;
        end else begin
            out_valid_out <= msg_valid_in;
            error_out <= 1'b0;
            tx_now_out <= msg_valid_in & hit;
            // Write one to clear first, so an event in the same cycle sets its bit again.
            if (wr_in && addr_in == `TLA_ADDR_ERRS) begin
                errs_reg <= errs_reg & ~wdata_in;
            end
            if (msg_valid_in) begin
                stream_or_control_index_out <= idx;
                circuit_packet_flag_out <= slot_ent[5];
                timestamp_advance_bit_out <= slot_ent[6];
                packet_counter_pick_out <= slot_ent[12:11];
                data_format_out <= ide0[21:20];
                out_addr_out <= cd_addr_in;
                out_type_out <= cd_type_in;
                out_payload_out <= cd_payload_in;
                if (mode == `TLA_MODE_PASS_PE) begin
                    out_addr_out <= pe_addr;
                    out_type_out <= pe_type;
                    out_payload_out <= pe_payload_in;
                end else if (mode == `TLA_MODE_MERGE) begin
                    if (mm == `TLA_MM_INSERT) begin
                        if (cd_empty) begin
                            out_addr_out <= pe_addr;
                            out_type_out <= pe_type;
                            out_payload_out <= pe_payload_in;
                        end else if (!pe_empty) begin
                            errs_reg[1] <= 1'b1;
                            error_out <= 1'b1;
                        end
                    end else if (mm != `TLA_MM_PASS && cd_empty) begin
                        out_addr_out <= pe_addr;
                        out_type_out <= pe_type;
                        out_payload_out <= pe_payload_in;
                    end else if (mm != `TLA_MM_PASS && !pe_empty) begin
                        if (pe_type != cd_type_in) begin
                            errs_reg[3] <= 1'b1;
                            error_out <= 1'b1;
                        end else begin
                            out_payload_out <= sum;
                            if (ovf) begin
                                errs_reg[0] <= 1'b1;
                                error_out <= 1'b1;
                            end
                            if (cd_ts_in != pe_ts_in[7:0]) begin
                                errs_reg[2] <= 1'b1;
                                error_out <= 1'b1;
                            end
                            if (pe_addr != cd_addr_in) begin
                                errs_reg[3] <= 1'b1;
                                error_out <= 1'b1;
                            end
                        end
                    end
                end
            end
            if (tick && slot_reg != 7'h00) begin
                errs_reg[4] <= 1'b1;
            end
        end
    end

    // Register read port, data in the following cycle.
    always @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_out <= 32'h00000000;
        end else if (rd_in) begin
            case (addr_in)
                `TLA_ADDR_CTRL: rdata_out <= ctrl_reg;
                `TLA_ADDR_TERM: rdata_out <= term_reg;
                `TLA_ADDR_STAT: rdata_out <= {13'h0000, data_cnt_reg, 1'b0, slot_reg};
                `TLA_ADDR_ERRS: rdata_out <= errs_reg;
                default: rdata_out <= 32'h00000000;
            endcase
        end else begin
            rdata_out <= 32'h00000000;
        end
    end
endmodule // tla_link

// file: logic/tla_regs.vh
// Constants for the transmit-link scheduler and merge unit.
// Assumes a single 20 MHz clock and a plain address/strobe register port.
// Behaviour
// - Each link uses a 21-entry identity table and an 84-entry slot table.
// - Identity table: sixteen stream entries, four control entries, one packet entry.
// - Identity entry holds mask, compare, header address, type, format, merge mode.
// - Slot entry holds packet flag, identity index and packet location.
// - Five counters per link: one data-slot counter, four control counters.
// - Data counter runs 0 to 1919; all counters clear on each 10 ms tick.
// - Control counters advance once per 21, 42 or 84 messages by rate.
// - Data slot sends when counter equals compare on every mask-selected bit.
// - Control counter counts from zero to its termination count, then wraps.
// - Control slot sends when selected control counter equals the compare field.
// - Counter select picks data or a control counter; control updates next cycle.
// - Slot index advances once per message and wraps after 84.
// - Slot entry gives stream index, packet flag, timestamp advance, packet pick.
// - Selected identity entry gives header address, type and merge mode.
// - Mask bit zero excludes a bit; zero mask and compare sends every slot.
// - A register holds the four termination counts; zero means no empty slots.
// - Sums saturate I and Q separately at 16/15 or 8/7 bits, flag overflow.
// - Insert overwrites an empty combiner message, else pass combiner, with error if the encoder slot is busy.
// - Merge is positional: sum, pass combiner, or insert encoder over empty.
// - Report overflows, alignment faults and header mismatches of several kinds.
// - Six merge units per link pair; default loops received link out.
`ifndef TLA_REGS_VH
`define TLA_REGS_VH
`define TLA_ADDR_CTRL 8'h00
`define TLA_ADDR_TERM 8'h04
`define TLA_ADDR_STAT 8'h08
`define TLA_ADDR_ERRS 8'h0C
`define TLA_ADDR_SLOTTAB 8'h40
`define TLA_ADDR_IDTAB0 8'hA0
`define TLA_ADDR_IDTAB1 8'hC0
`define TLA_CTRL_RESET 32'h00000000
`define TLA_SLOTS 7'h54
`define TLA_IDS 5'h15
`define TLA_DATA_LAST 11'h77F
`define TLA_MODE_OFF 2'h0
`define TLA_MODE_PASS_CD 2'h1
`define TLA_MODE_PASS_PE 2'h2
`define TLA_MODE_MERGE 2'h3
`define TLA_MM_SUM8 2'h0
`define TLA_MM_SUM16 2'h1
`define TLA_MM_INSERT 2'h2
`define TLA_MM_PASS 2'h3
`define TLA_TYPE_EMPTY 5'h00
`define TLA_TYPE_CTRL 5'h01
`define TLA_TYPE_WCDMA 5'h02
`endif
